/* File: inc/cfg_pkg.sv */
// Shared constants and types for the input-configuration register bank
package cfg_pkg;

	// ==========================================================
	// Serial configuration word layout
	localparam int WORD_BITS = 16;
	localparam int CONFIG_FLAG_BIT = 15;
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 11;
	localparam int FIELD_HI = 10;
	localparam int FIELD_LO = 3;
	localparam int COMMON_BIT = 2;

	// ==========================================================
	// Register selection codes in word bits 15:11
	localparam logic [4:0] PSEUDO_DIFF_SELECT_CODE = 5'h11;
	localparam logic [4:0] BIPOLAR_SELECT_CODE = 5'h12;
	localparam logic [4:0] UPPER_SCAN_SELECT_CODE = 5'h14;

	// ==========================================================
	// Reset values and fixed channel numbers
	localparam logic [7:0] PAIR_FIELD_RST = 8'h00;
	localparam logic [7:0] SCAN_FIELD_RST = 8'h00;
	localparam logic COMMON_REF_RST = 1'b0;
	localparam logic [15:0] MODE_WORD_RST = 16'h0000;
	localparam logic [3:0] COMMON_INPUT_CH = 4'hF;
	localparam logic [3:0] FIRST_CH = 4'h0;

	// ==========================================================
	// Where the negative side of a conversion comes from
	typedef enum logic [1:0] {
		NEG_GROUND,
		NEG_PARTNER,
		NEG_COMMON
	} neg_source_e;

endpackage

/* File: inc/cfg_word_if.sv */
// Carrier for received 16-bit words between receiver and register bank
`timescale 1ns/1ps
interface cfg_word_if;
	logic [15:0] word;
	logic valid;

	modport source (
		output word,
		output valid
	);
	modport sink (
		input word,
		input valid
	);
endinterface

/* File: rtl/serial_word_rx.sv */
// Serial word receiver: synchronises the pins and assembles 16-bit words
`timescale 1ns/1ps
module serial_word_rx
	import cfg_pkg::*;
#(
	parameter int WORD_W = WORD_BITS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic din_pin,
	cfg_word_if.source out
);
	localparam int CNT_W = $clog2(WORD_W + 1);

	// ==========================================================
	// Elaboration check
	if (WORD_W != WORD_BITS) begin : g_bad_width
		$error("serial_word_rx: word width must match the configuration word");
	end

	// ==========================================================
	// Pin synchronisers, two stages each
	logic [2:0] meta_q;
	logic [2:0] meta_d;
	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic sclk_prev_q;
	logic sclk_prev_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = {cs_n_pin, sclk_pin, din_pin};
		sync_d = meta_q;
		sclk_prev_d = sync_q[1];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 3'h7;
			sync_q <= 3'h7;
			sclk_prev_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			sclk_prev_q <= sclk_prev_d;
		end
	end

	// ==========================================================
	// Shift register and bit counter
	logic [WORD_W-1:0] shift_q;
	logic [WORD_W-1:0] shift_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic valid_q;
	logic valid_d;
	logic sclk_fall;

	// Data is taken on falling link clock edges, MSB first;
	// bits beyond the sixteenth of a frame are dropped
	always_comb begin
		sclk_fall = sclk_prev_q & ~sync_q[1];
		shift_d = shift_q;
		cnt_d = cnt_q;
		valid_d = 1'b0;
		if (sync_q[2]) begin
			cnt_d = '0;
		end else if (sclk_fall && cnt_q != CNT_W'(WORD_W)) begin
			shift_d = {shift_q[WORD_W-2:0], sync_q[0]};
			cnt_d = cnt_q + CNT_W'(1);
			valid_d = (cnt_q == CNT_W'(WORD_W - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_q <= '0;
			cnt_q <= '0;
			valid_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			valid_q <= valid_d;
		end
	end

	assign out.word = shift_q;
	assign out.valid = valid_q;
endmodule

/* File: rtl/adc_input_config_regs.sv */
// Input-configuration register bank and per-channel conversion decode
`timescale 1ns/1ps

// Behaviour
// - Word code 10001 in bits 15:11 writes the pseudo-differential pair register.
// - Word code 10010 in bits 15:11 writes the bipolar pair register.
// - Word code 10100 in bits 15:11 writes the upper-half scan enable register.
// - Pseudo-diff bits 10..3 set pairs 0/1..14/15 pseudo-differential; reset zero.
// - Pseudo-diff bit 2 refers inputs 0..14 to channel 15; reset zero.
// - Bipolar bits 10..3 select bipolar differential per pair; reset zero.
// - Scan bits 10..3 include channels 15..8 in custom scan; reset zero.
// - Common reference on: inputs 0..14 convert against common input, straight binary.
// - Only bipolar pair bit set: differential pair, two's complement coding.
// - Pseudo-diff pair bit set: differential pair, straight binary coding.
// - Both pair bits set: pseudo-diff setting wins, straight binary.
// - First serial bit one marks configuration; zero marks mode control.
// - Channel select always picks channel; in custom scan, scan bits decide if it is enabled.
module adc_input_config_regs
	import cfg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic DIN,
	input wire logic [3:0] CHANNEL_SELECT,
	input wire logic CUSTOM_SCAN_MODE,
	input wire logic [7:0] LOWER_SCAN_ENABLE,
	output logic [7:0] PSEUDO_DIFF_PAIRS,
	output logic COMMON_REFERENCE_ENABLE,
	output logic [7:0] BIPOLAR_PAIRS,
	output logic [15:0] SCAN_ENABLE_VECTOR,
	output logic [15:0] MODE_WORD,
	output logic MODE_WORD_STROBE,
	output logic [3:0] CONV_POS_CHANNEL,
	output logic [1:0] CONV_NEG_SOURCE,
	output logic CONV_TWOS_COMPLEMENT,
	output logic CONV_CHANNEL_ENABLED
);

	// ==========================================================
	// Helper functions
	// Word bit 10 belongs to pair 0, bit 3 to pair 7
	function automatic logic [7:0] field_to_pairs(input logic [15:0] w);
		logic [7:0] p;
		p = '0;
		for (int i = 0; i < 8; i++) begin
			p[i] = w[FIELD_HI - i];
		end
		return p;
	endfunction

	// Selection code match, used by each register write
	function automatic logic code_hit(input logic [15:0] w, input logic [4:0] code);
		return w[SEL_HI:SEL_LO] == code;
	endfunction

	// ==========================================================
	// Elaboration checks on the shared word layout
	// The pair decode walks exactly eight field bits, one per pair
	if (FIELD_HI - FIELD_LO != 7) begin : g_bad_field
		$error("adc_input_config_regs: pair field must be eight bits wide");
	end
	// Selection codes are compared as five-bit values
	if (SEL_HI - SEL_LO != 4) begin : g_bad_code
		$error("adc_input_config_regs: selection code must be five bits wide");
	end
	// The common bit must not overlap a pair bit or the selection code
	if (COMMON_BIT >= FIELD_LO) begin : g_bad_common
		$error("adc_input_config_regs: common bit must sit below the pair field");
	end
	// The configuration flag doubles as the top bit of every selection code
	if (CONFIG_FLAG_BIT != SEL_HI) begin : g_bad_flag
		$error("adc_input_config_regs: configuration flag must be the code's top bit");
	end
	// Every field must lie inside the received word
	if (SEL_HI >= WORD_BITS) begin : g_bad_word
		$error("adc_input_config_regs: field lies outside the configuration word");
	end

	// ==========================================================
	// Serial receiver
	cfg_word_if rx_word ();

	serial_word_rx #(
		.WORD_W(WORD_BITS)
	) u_rx (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.cs_n_pin(CS_N),
		.sclk_pin(SCLK),
		.din_pin(DIN),
		.out(rx_word.source)
	);

	// ==========================================================
	// Configuration registers
	logic [7:0] pseudo_pairs_q;
	logic [7:0] pseudo_pairs_d;
	logic common_ref_q;
	logic common_ref_d;
	logic [7:0] bipolar_pairs_q;
	logic [7:0] bipolar_pairs_d;
	logic [7:0] upper_scan_q;
	logic [7:0] upper_scan_d;
	logic [15:0] mode_word_q;
	logic [15:0] mode_word_d;
	logic mode_strobe_q;
	logic mode_strobe_d;
	logic is_config;

	// Write decode; other configuration codes belong to other banks
	always_comb begin
		pseudo_pairs_d = pseudo_pairs_q;
		common_ref_d = common_ref_q;
		bipolar_pairs_d = bipolar_pairs_q;
		upper_scan_d = upper_scan_q;
		mode_word_d = mode_word_q;
		mode_strobe_d = 1'b0;
		is_config = rx_word.word[CONFIG_FLAG_BIT];
		if (rx_word.valid && is_config) begin
			// Bits 2:0 or 1:0 of each word fall outside every field
			if (code_hit(rx_word.word, PSEUDO_DIFF_SELECT_CODE)) begin
				pseudo_pairs_d = field_to_pairs(rx_word.word);
				common_ref_d = rx_word.word[COMMON_BIT];
			end
			if (code_hit(rx_word.word, BIPOLAR_SELECT_CODE)) begin
				bipolar_pairs_d = field_to_pairs(rx_word.word);
			end
			if (code_hit(rx_word.word, UPPER_SCAN_SELECT_CODE)) begin
				upper_scan_d = rx_word.word[FIELD_HI:FIELD_LO];
			end
		end else if (rx_word.valid) begin
			// Mode control words are handed on untouched
			mode_word_d = rx_word.word;
			mode_strobe_d = 1'b1;
		end
	end

	// All fields start cleared
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pseudo_pairs_q <= PAIR_FIELD_RST;
			common_ref_q <= COMMON_REF_RST;
			bipolar_pairs_q <= PAIR_FIELD_RST;
			upper_scan_q <= SCAN_FIELD_RST;
			mode_word_q <= MODE_WORD_RST;
			mode_strobe_q <= 1'b0;
		end else begin
			pseudo_pairs_q <= pseudo_pairs_d;
			common_ref_q <= common_ref_d;
			bipolar_pairs_q <= bipolar_pairs_d;
			upper_scan_q <= upper_scan_d;
			mode_word_q <= mode_word_d;
			mode_strobe_q <= mode_strobe_d;
		end
	end

	// ==========================================================
	// Conversion decode for the selected channel
	logic [3:0] pos_ch_q;
	logic [3:0] pos_ch_d;
	neg_source_e neg_src_q;
	neg_source_e neg_src_d;
	logic twos_q;
	logic twos_d;
	logic enabled_q;
	logic enabled_d;
	logic [2:0] pair_idx;
	logic [15:0] scan_vec;

	// Priority: common reference, then pseudo-diff, then bipolar.
	// Channel 15 is the common input itself, so it never refers to itself.
	always_comb begin
		pair_idx = CHANNEL_SELECT[3:1];
		scan_vec = {upper_scan_q, LOWER_SCAN_ENABLE};
		pos_ch_d = CHANNEL_SELECT;
		neg_src_d = NEG_GROUND;
		twos_d = 1'b0;
		if (common_ref_q && CHANNEL_SELECT != COMMON_INPUT_CH) begin
			neg_src_d = NEG_COMMON;
		end else if (pseudo_pairs_q[pair_idx]) begin
			// Pseudo-diff wins over bipolar on the same pair
			pos_ch_d = {pair_idx, 1'b0};
			neg_src_d = NEG_PARTNER;
		end else if (bipolar_pairs_q[pair_idx]) begin
			pos_ch_d = {pair_idx, 1'b0};
			neg_src_d = NEG_PARTNER;
			twos_d = 1'b1;
		end
		// Otherwise single-ended to ground in straight binary
		enabled_d = CUSTOM_SCAN_MODE ? scan_vec[CHANNEL_SELECT] : 1'b1;
	end

	// Registered so the decode never glitches while the channel changes
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pos_ch_q <= FIRST_CH;
			neg_src_q <= NEG_GROUND;
			twos_q <= 1'b0;
			enabled_q <= 1'b1;
		end else begin
			pos_ch_q <= pos_ch_d;
			neg_src_q <= neg_src_d;
			twos_q <= twos_d;
			enabled_q <= enabled_d;
		end
	end

	// ==========================================================
	// Outputs; all but the lower scan half come from flip-flops.
	// The lower half belongs to another bank and passes straight through.
	assign PSEUDO_DIFF_PAIRS = pseudo_pairs_q;
	assign COMMON_REFERENCE_ENABLE = common_ref_q;
	assign BIPOLAR_PAIRS = bipolar_pairs_q;
	assign SCAN_ENABLE_VECTOR = {upper_scan_q, LOWER_SCAN_ENABLE};
	assign MODE_WORD = mode_word_q;
	assign MODE_WORD_STROBE = mode_strobe_q;
	assign CONV_POS_CHANNEL = pos_ch_q;
	assign CONV_NEG_SOURCE = neg_src_q;
	assign CONV_TWOS_COMPLEMENT = twos_q;
	assign CONV_CHANNEL_ENABLED = enabled_q;
endmodule

/* File: tb/cfg_regs_sva.sv */
// Port-level assertion checker for the input-configuration register bank
`timescale 1ns/1ps
module cfg_regs_sva
	import cfg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [3:0] CHANNEL_SELECT,
	input wire logic CUSTOM_SCAN_MODE,
	input wire logic [7:0] LOWER_SCAN_ENABLE,
	input wire logic [7:0] PSEUDO_DIFF_PAIRS,
	input wire logic COMMON_REFERENCE_ENABLE,
	input wire logic [7:0] BIPOLAR_PAIRS,
	input wire logic [15:0] SCAN_ENABLE_VECTOR,
	input wire logic MODE_WORD_STROBE,
	input wire logic [3:0] CONV_POS_CHANNEL,
	input wire logic [1:0] CONV_NEG_SOURCE,
	input wire logic CONV_TWOS_COMPLEMENT,
	input wire logic CONV_CHANNEL_ENABLED
);
	// ==========================================================
	// Pair bits of the selected channel; channel 15 ignores common mode
	logic com, pd, bp;
	assign com = COMMON_REFERENCE_ENABLE && CHANNEL_SELECT != 4'hF;
	assign pd = PSEUDO_DIFF_PAIRS[CHANNEL_SELECT[3:1]];
	assign bp = BIPOLAR_PAIRS[CHANNEL_SELECT[3:1]];

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Properties
	property p_rst; $rose(RST_N) |-> !COMMON_REFERENCE_ENABLE && PSEUDO_DIFF_PAIRS == 8'h00
		&& BIPOLAR_PAIRS == 8'h00 && SCAN_ENABLE_VECTOR[15:8] == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("register not cleared");
	property p_com; com |=> CONV_NEG_SOURCE == NEG_COMMON && !CONV_TWOS_COMPLEMENT
		&& CONV_POS_CHANNEL == $past(CHANNEL_SELECT); endproperty
	a_com: assert property (p_com) else $error("common decode wrong");
	property p_uni; !com && pd |=> CONV_NEG_SOURCE == NEG_PARTNER && !CONV_TWOS_COMPLEMENT
		&& CONV_POS_CHANNEL == {$past(CHANNEL_SELECT[3:1]), 1'b0}; endproperty
	a_uni: assert property (p_uni) else $error("pseudo pair decode wrong");
	property p_bip; !com && !pd && bp |=> CONV_NEG_SOURCE == NEG_PARTNER && CONV_TWOS_COMPLEMENT;
	endproperty
	a_bip: assert property (p_bip) else $error("bipolar decode wrong");
	property p_se; !com && !pd && !bp |=> CONV_NEG_SOURCE == NEG_GROUND && !CONV_TWOS_COMPLEMENT
		&& CONV_POS_CHANNEL == $past(CHANNEL_SELECT); endproperty
	a_se: assert property (p_se) else $error("single-ended decode wrong");
	property p_scan; 1'b1 |=> CONV_CHANNEL_ENABLED == ($past(CUSTOM_SCAN_MODE) ?
		$past(SCAN_ENABLE_VECTOR[CHANNEL_SELECT]) : 1'b1); endproperty
	a_scan: assert property (p_scan) else $error("channel enable wrong");
	property p_one; $changed(PSEUDO_DIFF_PAIRS) || $changed(COMMON_REFERENCE_ENABLE) |->
		$stable(BIPOLAR_PAIRS) && $stable(SCAN_ENABLE_VECTOR[15:8]); endproperty
	a_one: assert property (p_one) else $error("two registers written at once");
	property p_stb; MODE_WORD_STROBE |=> !MODE_WORD_STROBE && $stable(PSEUDO_DIFF_PAIRS)
		&& $stable(BIPOLAR_PAIRS); endproperty
	a_stb: assert property (p_stb) else $error("mode strobe wrong");
	c_com: cover property (com);
	c_both: cover property (!com && pd && bp);
	c_stb: cover property (MODE_WORD_STROBE);
endmodule

/* File: tb/host_model.sv */
// Host serial controller model that shifts configuration words in
`timescale 1ns/1ps
module host_model (
	output logic cs_n,
	output logic sclk,
	output logic din
);
	// Idle: frame deselected, link clock parked high
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b1;
	end

	// ==========================================================
	// Word shift, MSB first, bit settled before each falling edge
	task automatic send(input logic [15:0] w, input int n);
		cs_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			din = w[i];
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#62.5 cs_n = 1'b1;
		din = ~din; // Released line must not show a stale bit
		#100;
	endtask
endmodule

/* File: tb/tb.sv */
// Self-checking testbench for the input-configuration register bank
`timescale 1ns/1ps
module tb
	import cfg_pkg::*;
;
	// Pair bits by pair number; word bit 10 carries pair 0, so fields go mirrored
	localparam logic [7:0] PD = 8'h16;
	localparam logic [7:0] PD_FIELD = 8'h68;
	localparam logic [7:0] BP = 8'h9A;
	localparam logic [7:0] BP_FIELD = 8'h59;
	// Uneven patterns, so a mirrored bit order cannot pass unnoticed
	localparam logic [15:0] SCAN_EXP = 16'h835A;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [3:0] CHANNEL_SELECT = 4'h0;
	logic CUSTOM_SCAN_MODE = 1'b0;
	logic [7:0] LOWER_SCAN_ENABLE = 8'h00;
	logic CS_N, SCLK, DIN, COMMON_REFERENCE_ENABLE, MODE_WORD_STROBE;
	logic CONV_TWOS_COMPLEMENT, CONV_CHANNEL_ENABLED;
	logic [7:0] PSEUDO_DIFF_PAIRS, BIPOLAR_PAIRS;
	logic [15:0] SCAN_ENABLE_VECTOR, MODE_WORD;
	logic [3:0] CONV_POS_CHANNEL;
	logic [1:0] CONV_NEG_SOURCE;
	int num_errors = 0;
	int tests_run = 0;
	int mode_pulses = 0;

	host_model host_u (.cs_n(CS_N), .sclk(SCLK), .din(DIN));
	adc_input_config_regs dut_u (.SYS_CLK, .RST_N, .CS_N, .SCLK, .DIN, .CHANNEL_SELECT,
		.CUSTOM_SCAN_MODE, .LOWER_SCAN_ENABLE, .PSEUDO_DIFF_PAIRS, .COMMON_REFERENCE_ENABLE,
		.BIPOLAR_PAIRS, .SCAN_ENABLE_VECTOR, .MODE_WORD, .MODE_WORD_STROBE, .CONV_POS_CHANNEL,
		.CONV_NEG_SOURCE, .CONV_TWOS_COMPLEMENT, .CONV_CHANNEL_ENABLED);

	// 100 MHz system clock
	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	// Mode word pulses seen so far; configuration words must never raise one
	always @(posedge SYS_CLK) begin
		if (MODE_WORD_STROBE === 1'b1) mode_pulses++;
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [4:0] code, input logic [7:0] f, input logic [2:0] lo);
		host_u.send({code, f, lo}, 16);
	endtask

	// Expected {channel, negative source, coding} with PD and BP loaded
	function automatic logic [6:0] expv(input int c, input logic com);
		int p = c / 2;
		if (com && c != 15) return {c[3:0], NEG_COMMON, 1'b0};
		if (PD[p]) return {p[2:0], 1'b0, NEG_PARTNER, 1'b0};
		if (BP[p]) return {p[2:0], 1'b0, NEG_PARTNER, 1'b1};
		return {c[3:0], NEG_GROUND, 1'b0};
	endfunction

	// ==========================================================
	// Scenarios
	task automatic do_reset();
		@(posedge SYS_CLK) RST_N <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		#1;
		chk({PSEUDO_DIFF_PAIRS, BIPOLAR_PAIRS}, 16'h0000);
		chk({14'h0000, COMMON_REFERENCE_ENABLE, CONV_CHANNEL_ENABLED}, 16'h0001);
		chk(SCAN_ENABLE_VECTOR, {8'h00, LOWER_SCAN_ENABLE});
		chk(MODE_WORD, 16'h0000);
	endtask

	// Writes, foreign code, short frame and a mode word must not disturb others
	task automatic t_regs();
		wr(PSEUDO_DIFF_SELECT_CODE, PD_FIELD, 3'h7);
		chk({PSEUDO_DIFF_PAIRS, 7'h00, COMMON_REFERENCE_ENABLE}, {PD, 8'h01});
		wr(BIPOLAR_SELECT_CODE, BP_FIELD, 3'h3);
		chk({BIPOLAR_PAIRS, PSEUDO_DIFF_PAIRS}, {BP, PD});
		wr(UPPER_SCAN_SELECT_CODE, 8'h83, 3'h7);
		chk(SCAN_ENABLE_VECTOR, {8'h83, LOWER_SCAN_ENABLE});
		wr(5'h13, 8'hFF, 3'h7);
		host_u.send({PSEUDO_DIFF_SELECT_CODE, 11'h000}, 8);
		chk({BIPOLAR_PAIRS, PSEUDO_DIFF_PAIRS}, {BP, PD});
		chk({SCAN_ENABLE_VECTOR[15:8], 7'h00, COMMON_REFERENCE_ENABLE}, 16'h8301);
		chk(16'(mode_pulses), 16'h0000);
		host_u.send(16'h1234, 16);
		chk(MODE_WORD, 16'h1234);
		chk(16'(mode_pulses), 16'h0001);
		chk({BIPOLAR_PAIRS, PSEUDO_DIFF_PAIRS}, {BP, PD});
	endtask

	task automatic t_dec(input logic com);
		for (int c = 0; c < 16; c++) begin
			@(posedge SYS_CLK) CHANNEL_SELECT <= 4'(c);
			repeat (2) @(posedge SYS_CLK);
			#1;
			chk({9'h000, CONV_POS_CHANNEL, CONV_NEG_SOURCE, CONV_TWOS_COMPLEMENT},
				{9'h000, expv(c, com)});
		end
	endtask

	task automatic t_scan();
		@(posedge SYS_CLK) CUSTOM_SCAN_MODE <= 1'b1;
		LOWER_SCAN_ENABLE <= 8'h5A;
		for (int c = 0; c < 16; c++) begin
			@(posedge SYS_CLK) CHANNEL_SELECT <= 4'(c);
			repeat (2) @(posedge SYS_CLK);
			#1;
			chk({15'h0000, CONV_CHANNEL_ENABLED}, {15'h0000, SCAN_EXP[c]});
		end
		chk(SCAN_ENABLE_VECTOR, SCAN_EXP);
		@(posedge SYS_CLK) CUSTOM_SCAN_MODE <= 1'b0;
		CHANNEL_SELECT <= 4'h0;
		repeat (2) @(posedge SYS_CLK);
		#1;
		chk({15'h0000, CONV_CHANNEL_ENABLED}, 16'h0001);
	endtask

	// Main sequence, ending with a reset in mid-run
	initial begin
		do_reset();
		t_regs();
		t_dec(1'b1);
		wr(PSEUDO_DIFF_SELECT_CODE, PD_FIELD, 3'h3);
		t_dec(1'b0);
		t_scan();
		do_reset();
		stop_test();
	end

	// Watchdog against a hung run
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule

bind adc_input_config_regs cfg_regs_sva chk_u (.SYS_CLK, .RST_N, .CHANNEL_SELECT,
	.CUSTOM_SCAN_MODE, .LOWER_SCAN_ENABLE, .PSEUDO_DIFF_PAIRS, .COMMON_REFERENCE_ENABLE,
	.BIPOLAR_PAIRS, .SCAN_ENABLE_VECTOR, .MODE_WORD_STROBE, .CONV_POS_CHANNEL,
	.CONV_NEG_SOURCE, .CONV_TWOS_COMPLEMENT, .CONV_CHANNEL_ENABLED);
